//--- verilog/cbs_sequencer.sv
`timescale 1ns/1ps
module cbs_sequencer
	import cbs_pkg::*;
#(
	parameter int QDEPTH = CBS_QUEUE_DEPTH
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	// pins
	input wire logic ready_in, // async target ready
	input wire logic config_strap_in, // high: own control outputs
	input wire logic [7:0] mux_addr_data_low_in,
	output logic [7:0] mux_addr_data_low_out,
	output logic mux_addr_data_low_oe_b_out,
	output logic [7:0] addr_mid_byte_out,
	output logic [3:0] addr_status_high_out,
	output logic addr_oe_b_out,
	output logic addr_latch_strobe_out,
	output logic read_strobe_out,
	output logic write_strobe_out,
	output logic io_mem_sel_out,
	output logic xfer_direction_out,
	output logic data_buf_enable_out,
	output logic status_bit_min_out,
	output logic bus_release_ack_out,
	output logic irq_acknowledge_out,
	output logic ctrl_oe_b_out,
	// exec unit side
	input wire logic exec_req_in,
	input wire logic exec_write_in,
	input wire logic exec_io_in,
	input wire logic [1:0] exec_seg_in,
	input wire logic [19:0] exec_addr_in,
	input wire logic [7:0] exec_wdata_in,
	output logic exec_done_out,
	output logic [7:0] exec_rdata_out,
	// prefetch queue side
	input wire logic q_pop_in,
	input wire logic q_flush_in,
	input wire logic [19:0] q_flush_addr_in,
	output logic q_valid_out,
	output logic [7:0] q_byte_out
);

	// ----------------------------------------
	// synchronisers for pin inputs
	// ----------------------------------------
	logic ready_s1_r, ready_s2_r; // ready two-stage
	logic strap_s1_r, strap_s2_r; // strap two-stage
	logic [7:0] din_s1_r, din_s2_r; // bus data two-stage

	// first stages feed only the second stages
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ready_s1_r <= 1'b0;
			ready_s2_r <= 1'b0;
			strap_s1_r <= 1'b0;
			strap_s2_r <= 1'b0;
			din_s1_r <= CBS_DATA_RESET;
			din_s2_r <= CBS_DATA_RESET;
		end else begin
			ready_s1_r <= ready_in;
			ready_s2_r <= ready_s1_r;
			strap_s1_r <= config_strap_in;
			strap_s2_r <= strap_s1_r;
			din_s1_r <= mux_addr_data_low_in;
			din_s2_r <= din_s1_r;
		end
	end

	// ----------------------------------------
	// state and cycle registers
	// ----------------------------------------
	cbs_state_t state_r, state_nxt;
	logic [19:0] cyc_addr_r; // latched target address
	logic [7:0] cyc_wdata_r; // latched write data
	logic cyc_write_r, cyc_io_r, cyc_fetch_r;
	logic [1:0] cyc_seg_r; // segment tag for status
	logic discard_r; // fetch byte dropped after flush
	logic [19:0] fetch_addr_r; // next prefetch address
	logic [7:0] q_mem_r [QDEPTH]; // prefetch storage
	logic [1:0] q_wr_r, q_rd_r; // queue pointers
	logic [2:0] q_cnt_r; // bytes held
	logic exec_done_r;
	logic [7:0] exec_rdata_r;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire in_ti = (state_r == ST_TI);
	wire in_t1 = (state_r == ST_T1);
	wire in_t2 = (state_r == ST_T2);
	wire in_t3 = (state_r == ST_T3);
	wire in_tw = (state_r == ST_TW);
	wire in_t4 = (state_r == ST_T4);
	wire strobe_ph = in_t2 | in_t3 | in_tw; // strobes live here
	// a cycle may begin from idle or straight after T4
	wire start_ok = in_ti | in_t4;
	wire push = in_t4 & cyc_fetch_r & ~discard_r;
	wire pop = q_pop_in & (q_cnt_r != 3'h0) & ~q_flush_in;
	wire [2:0] q_cnt_eff = q_cnt_r + {2'h0, push};
	// the just-served request is masked in its T4 and the cycle after, while done is high
	wire exec_mask = exec_done_r | (in_t4 & ~cyc_fetch_r);
	wire take_exec = start_ok & exec_req_in & ~exec_mask;
	// refill only with room and no pending exec request
	wire take_fetch = start_ok & ~exec_req_in & ~q_flush_in
		& (q_cnt_eff < 3'(QDEPTH));
	wire take = take_exec | take_fetch;

	// ----------------------------------------
	// T-state sequencing
	// ----------------------------------------
	always_comb begin
		case (state_r)
			ST_TI: state_nxt = take ? ST_T1 : ST_TI;
			ST_T1: state_nxt = ST_T2;
			ST_T2: state_nxt = ST_T3;
			// ready seen at end of T3 or a wait leads to T4
			ST_T3: state_nxt = ready_s2_r ? ST_T4 : ST_TW;
			ST_TW: state_nxt = ready_s2_r ? ST_T4 : ST_TW;
			ST_T4: state_nxt = take ? ST_T1 : ST_TI;
			default: state_nxt = ST_TI;
		endcase
	end

	// state register
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= ST_TI;
		end else begin
			state_r <= state_nxt;
		end
	end

	// cycle parameters captured when a cycle is taken
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cyc_addr_r <= CBS_ADDR_RESET;
			cyc_wdata_r <= CBS_DATA_RESET;
			cyc_write_r <= 1'b0;
			cyc_io_r <= 1'b0;
			cyc_fetch_r <= 1'b0;
			cyc_seg_r <= 2'h0;
		end else if (take_exec) begin
			cyc_addr_r <= exec_addr_in;
			cyc_wdata_r <= exec_wdata_in;
			cyc_write_r <= exec_write_in;
			cyc_io_r <= exec_io_in;
			cyc_fetch_r <= 1'b0;
			cyc_seg_r <= exec_seg_in;
		end else if (take_fetch) begin
			// exec wins over refill; fetch is a memory read
			cyc_addr_r <= fetch_addr_r;
			cyc_write_r <= 1'b0;
			cyc_io_r <= 1'b0;
			cyc_fetch_r <= 1'b1;
			cyc_seg_r <= CBS_SEG_CODE;
		end
	end

	// ----------------------------------------
	// prefetch queue and fetch pointer
	// ----------------------------------------
	// flush drops queue and marks an in-flight fetch stale
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fetch_addr_r <= CBS_RESET_FETCH_ADDR;
			discard_r <= 1'b0;
		end else if (q_flush_in) begin
			fetch_addr_r <= q_flush_addr_in;
			discard_r <= ~in_ti & ~(in_t4 & ~take);
		end else begin
			if (take_fetch) begin
				fetch_addr_r <= fetch_addr_r + 20'h00001;
			end
			if (take) begin
				discard_r <= 1'b0;
			end
		end
	end

	// queue storage, written with the byte read in the fetch
	always_ff @(posedge clock_in) begin
		if (push) begin
			q_mem_r[q_wr_r] <= din_s2_r;
		end
	end

	// pointers and count
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			q_wr_r <= 2'h0;
			q_rd_r <= 2'h0;
			q_cnt_r <= 3'h0;
		end else if (q_flush_in) begin
			q_wr_r <= 2'h0;
			q_rd_r <= 2'h0;
			q_cnt_r <= 3'h0;
		end else begin
			q_wr_r <= q_wr_r + {1'b0, push};
			q_rd_r <= q_rd_r + {1'b0, pop};
			q_cnt_r <= q_cnt_r + {2'h0, push} - {2'h0, pop};
		end
	end

	assign q_valid_out = (q_cnt_r != 3'h0);
	assign q_byte_out = q_mem_r[q_rd_r];

	// ----------------------------------------
	// exec unit answer
	// ----------------------------------------
	// read byte taken at end of T4: pins from the cycle before the last T3/TW
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			exec_done_r <= 1'b0;
			exec_rdata_r <= CBS_DATA_RESET;
		end else begin
			exec_done_r <= in_t4 & ~cyc_fetch_r;
			if (in_t4 & ~cyc_fetch_r & ~cyc_write_r) begin
				exec_rdata_r <= din_s2_r;
			end
		end
	end

	assign exec_done_out = exec_done_r;
	assign exec_rdata_out = exec_rdata_r;

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// address in T1, write data T2..T4, float on read
	wire ad_drive = in_t1 | (cyc_write_r & ~in_ti & ~in_t1);
	assign mux_addr_data_low_oe_b_out = ~ad_drive;
	assign mux_addr_data_low_out = in_t1 ? cyc_addr_r[7:0]
		: cyc_wdata_r;
	// middle byte stays put from T1 through T4
	assign addr_mid_byte_out = cyc_addr_r[15:8];
	assign addr_oe_b_out = in_ti;
	// high address in T1, then status nibble
	assign addr_status_high_out = in_t1 ? cyc_addr_r[19:16]
		: {2'h0, cyc_seg_r};
	assign addr_latch_strobe_out = in_t1;
	// strobes follow the address and drop in T4
	assign read_strobe_out = strobe_ph & ~cyc_write_r;
	assign write_strobe_out = strobe_ph & cyc_write_r;
	assign io_mem_sel_out = cyc_io_r;
	assign xfer_direction_out = cyc_write_r;
	assign data_buf_enable_out = strobe_ph;
	assign status_bit_min_out = cyc_fetch_r;
	// hold and interrupt acknowledge are not served here
	assign bus_release_ack_out = 1'b0;
	assign irq_acknowledge_out = 1'b0;
	// strap low hands control pins to an external controller
	assign ctrl_oe_b_out = ~strap_s2_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);

	sequence s_head;
		in_t2 ##1 in_t3;
	endsequence
	sequence s_wr_hold;
		$stable(mux_addr_data_low_out) && !mux_addr_data_low_oe_b_out;
	endsequence

	chk_cycle_order: assert property (in_t1 |=> s_head)
		else $error("cycle skipped a T-state");
	chk_ready_exit: assert property ((in_t3 || in_tw) && ready_s2_r
		|=> in_t4)
		else $error("ready seen but no T4");
	chk_wait_insert: assert property ((in_t3 || in_tw) && !ready_s2_r
		|=> in_tw)
		else $error("missing wait state");
	chk_addr_in_t1: assert property (in_t1 |->
		mux_addr_data_low_out == cyc_addr_r[7:0]
		&& !mux_addr_data_low_oe_b_out)
		else $error("address not on bus in T1");
	chk_write_stable: assert property (cyc_write_r && (in_t3 || in_tw
		|| in_t4) |-> s_wr_hold)
		else $error("write data moved");
	chk_read_float: assert property (!cyc_write_r && (in_t2 || in_t3)
		|-> mux_addr_data_low_oe_b_out)
		else $error("read cycle drives bus");
	chk_mid_hold: assert property (!in_t1 && !in_ti
		|-> $stable(addr_mid_byte_out))
		else $error("middle byte changed");
	chk_strobe_end: assert property (in_t4 |-> !read_strobe_out
		&& !write_strobe_out)
		else $error("strobe active in T4");
	chk_exec_first: assert property (start_ok && exec_req_in && !exec_mask
		|=> in_t1 && !cyc_fetch_r)
		else $error("exec request not served first");
	chk_queue_room: assert property (q_cnt_r <= 3'(QDEPTH))
		else $error("prefetch queue overrun");

endmodule

//--- pkg/cbs_pkg.sv
// Contract
// - cycles last four or more T-states
// - address first, then read or write strobe
// - target address driven during T1
// - write data driven T2 through T4
// - read floats in T2, samples T3-T4; code takes the pins from the cycle before the last T3/TW
// - cycles only for exec or prefetch refill
// - wait states inserted between T3, T4
// - bus data unchanged during wait states
// - wide variant floats or drives low lines
// - status on upper lines from T2 on
// - strobes drop in T4, target deselects
// - middle address byte held whole cycle
// - low byte: address off in T2
// - strap high enables own control outputs
// - fetch when queue has room, no exec
// - running fetch finishes before exec served
package cbs_pkg;

	// ----------------------------------------
	// bus cycle states, one-hot
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_TI = 6'h01, // idle between cycles
		ST_T1 = 6'h02, // address phase
		ST_T2 = 6'h04, // turnaround, status out
		ST_T3 = 6'h08, // data phase
		ST_TW = 6'h10, // wait state
		ST_T4 = 6'h20 // cycle end
	} cbs_state_t;

	// ----------------------------------------
	// constants
	// ----------------------------------------
	localparam int CBS_QUEUE_DEPTH = 4; // prefetch bytes
	localparam logic [19:0] CBS_RESET_FETCH_ADDR = 20'hFFFF0;
	localparam logic [1:0] CBS_SEG_CODE = 2'h2; // code segment tag
	localparam logic [7:0] CBS_DATA_RESET = 8'h00;
	localparam logic [19:0] CBS_ADDR_RESET = 20'h00000;

endpackage

//--- tb/cbs_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// memory and peripheral side of the bus
// ----------------------------------------
module cbs_mem_model (
	input wire logic clock_in,
	input wire logic ale_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [7:0] drv_in, // device low byte value
	input wire logic oe_b_in, // low: device drives low byte
	input wire logic [7:0] mid_in,
	input wire logic [3:0] stat_in,
	input wire logic [3:0] waits_in, // strobe cycles before ready
	input wire logic addr_oe_b_in, // low: address lines driven
	input wire logic buf_en_in, // data buffer enable
	input wire logic io_in, // high: I/O cycle
	input wire logic dir_in, // high: write direction
	input wire logic fetch_in, // prefetch status bit
	output logic ready_out,
	output logic [7:0] pin_out // resolved low byte level
);
	logic [19:0] addr_r = 20'h00000; // external latch copy
	logic [19:0] waddr_r = 20'h00000; // last write address
	logic [7:0] wdata_r = 8'h00; // last write byte
	logic [3:0] wstat_r = 4'h0; // status seen in write
	logic [7:0] last_r = 8'h00; // last level on the pins
	logic [3:0] cnt_r = 4'h0; // strobe cycles so far
	logic [7:0] gap_r = 8'h00; // cycles since last address latch strobe
	logic [7:0] min_gap_r = 8'hFF; // shortest cycle seen
	logic [7:0] bad_r = 8'h00; // unstable bus events
	logic rd_d_r = 1'b0; // read strobe late: keeps data in T4
	logic wr_d_r = 1'b0;
	logic [2:0] ctl_r = 3'h0; // io, dir, fetch seen in strobes
	logic [3:0] len_r = 4'h0; // strobe cycles of the last cycle
	// data pattern depends on every address bit
	function automatic logic [7:0] mem_f(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {a[19:16], 4'hA};
	endfunction
	// slow targets hold ready low for a few strobe cycles
	assign ready_out = (cnt_r >= waits_in);
	// no pull-up: a released bus shows the inverse of the last level
	assign pin_out = !oe_b_in ? drv_in :
		(rd_in | rd_d_r) ? mem_f(addr_r) : ~last_r;
	// latch, capture and watch the bus
	always @(posedge clock_in) begin
		last_r <= pin_out;
		rd_d_r <= rd_in;
		wr_d_r <= wr_in;
		cnt_r <= (rd_in | wr_in) ? cnt_r + 4'h1 : 4'h0;
		gap_r <= ale_in ? 8'h01 : (gap_r == 8'hFF ? gap_r : gap_r + 8'h01);
		if (ale_in) begin
			addr_r <= {stat_in, mid_in, drv_in};
			if (gap_r < min_gap_r)
				min_gap_r <= gap_r;
		end
		if (wr_in) begin
			waddr_r <= addr_r;
			wdata_r <= drv_in;
			wstat_r <= stat_in;
		end
		if (rd_in | wr_in)
			ctl_r <= {io_in, dir_in, fetch_in};
		if (!(rd_in | wr_in) && cnt_r != 4'h0)
			len_r <= cnt_r;
		if ((ale_in | rd_in | wr_in) && addr_oe_b_in != 1'b0)
			bad_r <= bad_r + 8'h01;
		if (buf_en_in != (rd_in | wr_in))
			bad_r <= bad_r + 8'h01;
		if ((rd_in | wr_in) && mid_in !== addr_r[15:8])
			bad_r <= bad_r + 8'h01;
		if (wr_in && (oe_b_in || (wr_d_r && drv_in !== wdata_r)))
			bad_r <= bad_r + 8'h01;
	end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench for the bus cycle sequencer
// ----------------------------------------
module tb_top;
	import cbs_pkg::*;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic ready;
	logic [7:0] pins;
	logic exec_req = 1'b0;
	logic exec_wr = 1'b0;
	logic [1:0] seg = 2'h0;
	logic [19:0] addr = 20'h00000;
	logic [7:0] wdata = 8'h00;
	logic q_pop = 1'b0;
	logic q_flush = 1'b0;
	logic [19:0] q_faddr = 20'h00000;
	logic [3:0] waits = 4'h0; // wait request to the model
	logic strap = 1'b1; // configuration strap level
	logic io = 1'b0; // exec request targets I/O
	wire addr_oe_b, iom, dir, buf_en, sbit, rel_ack, irq_ack, ctrl_oe_b;
	wire [7:0] ad_out, mid, rdata, q_byte;
	wire [3:0] stat;
	wire ad_oe_b, ale, rd, wr, done, q_valid;
	int n_errors = 0;
	int checks_done = 0;
	int n;
	always #50 clock_in = ~clock_in;
	cbs_sequencer cbs_sequencer_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.ready_in(ready), .config_strap_in(strap),
		.mux_addr_data_low_in(pins), .mux_addr_data_low_out(ad_out),
		.mux_addr_data_low_oe_b_out(ad_oe_b), .addr_mid_byte_out(mid),
		.addr_status_high_out(stat), .addr_oe_b_out(addr_oe_b),
		.addr_latch_strobe_out(ale), .read_strobe_out(rd),
		.write_strobe_out(wr), .io_mem_sel_out(iom),
		.xfer_direction_out(dir), .data_buf_enable_out(buf_en),
		.status_bit_min_out(sbit), .bus_release_ack_out(rel_ack),
		.irq_acknowledge_out(irq_ack), .ctrl_oe_b_out(ctrl_oe_b),
		.exec_req_in(exec_req), .exec_write_in(exec_wr), .exec_io_in(io),
		.exec_seg_in(seg), .exec_addr_in(addr), .exec_wdata_in(wdata),
		.exec_done_out(done), .exec_rdata_out(rdata), .q_pop_in(q_pop),
		.q_flush_in(q_flush), .q_flush_addr_in(q_faddr),
		.q_valid_out(q_valid), .q_byte_out(q_byte));
	cbs_mem_model mem_i (.clock_in(clock_in), .ale_in(ale), .rd_in(rd),
		.wr_in(wr), .drv_in(ad_out), .oe_b_in(ad_oe_b), .mid_in(mid),
		.stat_in(stat), .waits_in(waits), .addr_oe_b_in(addr_oe_b),
		.buf_en_in(buf_en), .io_in(iom), .dir_in(dir), .fetch_in(sbit),
		.ready_out(ready), .pin_out(pins));
	// compare and count; unknowns never match
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one execution request, held until done; n counts its cycles
	task automatic exec(input logic w, input logic [19:0] a, input logic [1:0] s);
		@(posedge clock_in);
		exec_req <= 1'b1;
		exec_wr <= w;
		addr <= a;
		seg <= s;
		wdata <= a[7:0] ^ 8'h3C;
		for (n = 0; n < 200; n++) begin
			@(negedge clock_in);
			if (done === 1'b1)
				break;
		end
		// a request that is never answered ends the run as a failure
		if (done !== 1'b1) begin
			n_errors++;
			end_sim;
		end
		@(posedge clock_in);
		exec_req <= 1'b0;
	endtask
	// strap low releases the control pins, strap high drives them
	task automatic t_strap;
		@(posedge clock_in);
		strap <= 1'b0;
		repeat (3) @(negedge clock_in);
		chk(ctrl_oe_b, 20'h00001);
		@(posedge clock_in);
		strap <= 1'b1;
		repeat (3) @(negedge clock_in);
		chk(ctrl_oe_b, 20'h00000);
		chk({rel_ack, irq_ack}, 20'h00000);
	endtask
	// write cycle: address, data and status seen by the target
	task automatic t_write;
		waits <= 4'h0;
		exec(1'b1, 20'h3A5C1, 2'h1);
		chk(mem_i.waddr_r, 20'h3A5C1);
		chk(mem_i.wdata_r, 20'h000FD);
		chk(mem_i.wstat_r, 20'h00001);
		chk(mem_i.len_r, 20'h00002);
		chk(mem_i.ctl_r, 20'h00002);
	endtask
	// read cycle stretched by a slow target
	task automatic t_read;
		waits <= 4'h3;
		io <= 1'b1;
		exec(1'b0, 20'h51234, 2'h0);
		chk(rdata, mem_i.mem_f(20'h51234));
		chk(n > 5, 20'h00001);
		chk(mem_i.len_r, 20'h00006);
		chk(mem_i.ctl_r, 20'h00004);
		waits <= 4'h0;
		io <= 1'b0;
	endtask
	// queue refill after a flush, then idle once full
	task automatic t_fetch;
		int i;
		@(posedge clock_in);
		q_faddr <= 20'h0FFFE;
		q_flush <= 1'b1;
		@(posedge clock_in);
		q_flush <= 1'b0;
		repeat (80) @(posedge clock_in);
		chk(mem_i.gap_r > 30, 20'h00001);
		chk(mem_i.ctl_r, 20'h00001);
		for (i = 0; i < 4; i++) begin
			// look only after the pop edge has settled
			@(negedge clock_in);
			for (n = 0; n < 100 && q_valid !== 1'b1; n++)
				@(negedge clock_in);
			chk(q_byte, mem_i.mem_f(20'h0FFFE + 20'(i)));
			@(posedge clock_in);
			q_pop <= 1'b1;
			@(posedge clock_in);
			q_pop <= 1'b0;
		end
	endtask
	// verdict and end of run
	task automatic end_sim;
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog: the tests need well under 20000 cycles
	initial begin
		#2000000;
		n_errors++;
		end_sim;
	end
	// main sequence
	initial begin
		repeat (20) @(posedge clock_in);
		rst_b_in <= 1'b1;
		t_strap;
		t_write;
		t_read;
		t_fetch;
		exec(1'b0, 20'h00F0F, 2'h3);
		chk(rdata, mem_i.mem_f(20'h00F0F));
		chk(mem_i.min_gap_r >= 4, 20'h00001);
		chk(mem_i.bad_r, 20'h00000);
		end_sim;
	end
endmodule
